/* File: bench/test_cmc_top.sv */
// ****************************************************************
// self-checking bench for the converter mode control registers
// ****************************************************************
// assumes cmc_top with a two-wire serial port and a pulled-up data line
`include "cmc_regs.svh"
`default_nettype none
module test_cmc_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic scl_in = 1'b1;
  logic m_sda = 1'b1;
  logic sleep_pin = 1'b0;
  logic strap_p = 1'b0;
  logic strap_c = 1'b0;
  wire logic sda_line;
  logic sda_out, sda_oe_out, pfm, periph_en, periph_dis, proc_en, proc_dis, motor, wait_m, low_p;
  logic [1:0] uvlo, pvs;
  logic [2:0] pcode;
  logic [7:0] rd, v;
  logic a;
  logic [7:0] tab_p [5] = '{8'h80, 8'h21, 8'h42, 8'h63, 8'h00};
  int n_fail = 0;
  int check_count = 0;
  // ****************************************************************
  // pulled-up data line
  // ****************************************************************
  assign sda_line = m_sda & ~sda_oe_out;
  always #2.5 mclk_in = ~mclk_in;
  cmc_top u_dut (
    .mclk_in(mclk_in), .rst_in(rst_in), .scl_in(scl_in), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .sleep_request_pin_in(sleep_pin),
    .peripheral_default_pin_in(strap_p), .processor_default_pin_in(strap_c),
    .pfm_allowed_out(pfm), .undervoltage_threshold_sel_out(uvlo),
    .peripheral_voltage_sel_out(pvs), .peripheral_enable_out(periph_en),
    .peripheral_discharge_out(periph_dis), .processor_voltage_sel_out(pcode),
    .processor_enable_out(proc_en), .processor_discharge_out(proc_dis),
    .motor_drive_out(motor), .wait_mode_out(wait_m), .low_power_out(low_p)
  );
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : tick
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic do_reset(input logic p, input logic c);
    rst_in <= 1'b1;
    strap_p <= p;
    strap_c <= c;
    tick(20);
    rst_in <= 1'b0;
    tick(4);
  endtask : do_reset
  task automatic bit_io(input logic b, output logic s);
    m_sda <= b;
    tick(4);
    scl_in <= 1'b1;
    tick(3);
    #1;
    s = sda_line;
    tick(3);
    scl_in <= 1'b0;
    tick(2);
  endtask : bit_io
  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(mack, ack);
  endtask : xfer
  task automatic start_c;
    m_sda <= 1'b1;
    tick(4);
    scl_in <= 1'b1;
    tick(6);
    m_sda <= 1'b0;
    tick(6);
    scl_in <= 1'b0;
    tick(2);
  endtask : start_c
  task automatic stop_c;
    m_sda <= 1'b0;
    tick(4);
    scl_in <= 1'b1;
    tick(6);
    m_sda <= 1'b1;
    tick(6);
  endtask : stop_c
  task automatic send(input logic [7:0] b);
    logic [7:0] rx;
    logic ak;
    xfer(b, 1'b1, rx, ak);
    check({7'h00, ak}, 8'h00);
  endtask : send
  task automatic wr_reg(input logic [7:0] ofs, input logic [7:0] val);
    start_c();
    send({`CMC_DEV_ADDR, 1'b0});
    send(ofs);
    send(val);
    stop_c();
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] ofs, output logic [7:0] val);
    logic ak;
    start_c();
    send({`CMC_DEV_ADDR, 1'b0});
    send(ofs);
    start_c();
    send({`CMC_DEV_ADDR, 1'b1});
    xfer(8'hFF, 1'b1, val, ak);
    stop_c();
  endtask : rd_reg
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    for (int k = 0; k < 2; k++) begin
      do_reset(k[0], ~k[0]);
      rd_reg(`CMC_PERIPH_CTRL_OFS, rd);
      check(rd, {7'h19, k[0]});
      rd_reg(`CMC_PROC_CTRL_OFS, rd);
      check(rd, {3'h3, ~k[0], 4'h8});
      check({6'h00, pvs}, {7'h01, k[0]});
      check({5'h00, pcode}, {7'h03, ~k[0]});
      check({4'h0, uvlo, pfm, motor}, 8'h06);
    end
    foreach (tab_p[i]) begin
      wr_reg(`CMC_PERIPH_CTRL_OFS, tab_p[i]);
      rd_reg(`CMC_PERIPH_CTRL_OFS, rd);
      check(rd, tab_p[i]);
      check({5'h00, pfm, uvlo}, {5'h00, ~tab_p[i][7], tab_p[i][6:5]});
      check({6'h00, pvs}, {6'h00, tab_p[i][1:0]});
    end
    for (int i = 0; i < 8; i++) begin
      v = {1'b0, i[2:0], 2'h1, i[0], 1'b0};
      wr_reg(`CMC_PROC_CTRL_OFS, v);
      rd_reg(`CMC_PROC_CTRL_OFS, rd);
      check(rd, v);
      check({5'h00, pcode}, {5'h00, i[2:0]});
      check({7'h00, motor}, {7'h00, i[0]});
    end
    wr_reg(`CMC_PROC_CTRL_OFS, 8'h75);
    wr_reg(`CMC_PERIPH_CTRL_OFS, 8'h18);
    sleep_pin <= 1'b1;
    tick(6);
    check({4'h0, low_p, wait_m, proc_en, proc_dis}, 8'h0A);
    check({5'h00, pcode}, 8'h01);
    wr_reg(`CMC_PROC_CTRL_OFS, 8'hF5);
    check({6'h00, proc_en, proc_dis}, 8'h01);
    sleep_pin <= 1'b0;
    tick(6);
    check({5'h00, pcode}, 8'h07);
    check({6'h00, low_p, proc_en}, 8'h01);
    wr_reg(`CMC_PERIPH_CTRL_OFS, 8'h10);
    sleep_pin <= 1'b1;
    tick(6);
    check({6'h00, low_p, wait_m}, 8'h00);
    wr_reg(`CMC_PERIPH_CTRL_OFS, 8'h0C);
    check({4'h0, wait_m, periph_en, periph_dis, proc_dis}, 8'h0B);
    wr_reg(`CMC_PERIPH_CTRL_OFS, 8'h08);
    check({6'h00, wait_m, periph_dis}, 8'h02);
    sleep_pin <= 1'b0;
    rd_reg(8'h05, rd);
    check(rd, 8'h00);
    start_c();
    send({`CMC_DEV_ADDR, 1'b0});
    send(`CMC_PERIPH_CTRL_OFS);
    start_c();
    send({`CMC_DEV_ADDR, 1'b1});
    xfer(8'hFF, 1'b0, rd, a);
    check(rd, 8'h08);
    xfer(8'hFF, 1'b1, rd, a);
    check(rd, 8'hF5);
    stop_c();
    check({7'h00, sda_out}, 8'h00);
    start_c();
    xfer(8'hA0, 1'b1, rd, a);
    check({7'h00, a}, 8'h01);
    stop_c();
    tally_and_finish();
  end
  // ****************************************************************
  // watchdog
  // ****************************************************************
  initial begin
    tick(60000);
    n_fail++;
    tally_and_finish();
  end
endmodule : test_cmc_top
`default_nettype wire

/* File: common/cmc_pkg.sv */
// types of the converter mode control register bank
// assumes nothing beyond the register header
`default_nettype none
package cmc_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_PTR, ST_PACK, ST_WR, ST_WACK, ST_RD, ST_RACK
  } cmc_ser_state_t;
endpackage : cmc_pkg
`default_nettype wire

/* File: common/cmc_regs.svh */
// constants of the converter mode control register bank
// assumes one 200 MHz clock and a serial two-wire register port
`ifndef CMC_REGS_SVH
`define CMC_REGS_SVH
`define CMC_PERIPH_CTRL_OFS 8'h0C
`define CMC_PROC_CTRL_OFS 8'h0D
// arbitrary bus address of this device
`define CMC_DEV_ADDR 7'h48
`define CMC_PERIPH_CTRL_RST 8'h32
`define CMC_PROC_CTRL_RST 8'h68
`define CMC_FORCED_PWM_BIT 7
`define CMC_UVLO_HI 6
`define CMC_UVLO_LO 5
`define CMC_SLEEP_KIND_BIT 4
`define CMC_SLEEP_PIN_EN_BIT 3
`define CMC_PERIPH_DIS_BIT 2
`define CMC_PERIPH_V_HI 1
`define CMC_PERIPH_V_LO 0
`define CMC_PROC_OFF_BIT 7
`define CMC_PROC_V_HI 6
`define CMC_PROC_V_LO 4
`define CMC_PROC_SLP_HI 3
`define CMC_PROC_SLP_LO 2
`define CMC_MOTOR_BIT 1
`define CMC_PROC_DIS_BIT 0
`define CMC_BIT_COUNT 4'h8
`endif

/* File: hdl/cmc_top.sv */
// converter mode control registers with their two-wire serial slave
// assumes open-drain data line resolved outside, pins asynchronous to mclk_in
`include "cmc_regs.svh"
`default_nettype none
module cmc_top (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic sleep_request_pin_in,
  input wire logic peripheral_default_pin_in,
  input wire logic processor_default_pin_in,
  output logic pfm_allowed_out,
  output logic [1:0] undervoltage_threshold_sel_out,
  output logic [1:0] peripheral_voltage_sel_out,
  output logic peripheral_enable_out,
  output logic peripheral_discharge_out,
  output logic [2:0] processor_voltage_sel_out,
  output logic processor_enable_out,
  output logic processor_discharge_out,
  output logic motor_drive_out,
  output logic wait_mode_out,
  output logic low_power_out
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] scl_s;
  logic [1:0] sda_s;
  logic [1:0] slp_s;
  logic [1:0] pdef_s;
  logic [1:0] cdef_s;
  logic scl_d;
  logic sda_d;
  always_ff @(posedge mclk_in) begin
    scl_s <= {scl_s[0], scl_in};
    sda_s <= {sda_s[0], sda_in};
    slp_s <= {slp_s[0], sleep_request_pin_in};
    pdef_s <= {pdef_s[0], peripheral_default_pin_in};
    cdef_s <= {cdef_s[0], processor_default_pin_in};
    scl_d <= scl_s[1];
    sda_d <= sda_s[1];
  end
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  assign scl_rise = scl_s[1] & ~scl_d;
  assign scl_fall = ~scl_s[1] & scl_d;
  assign start_cond = scl_s[1] & scl_d & sda_d & ~sda_s[1];
  assign stop_cond = scl_s[1] & scl_d & ~sda_d & sda_s[1];

  // ****************************************
  // register bank
  // ****************************************
  logic [7:0] periph_ctrl;
  logic [7:0] proc_ctrl;
  logic wr_pulse;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      periph_ctrl <= `CMC_PERIPH_CTRL_RST | {7'h00, pdef_s[1]};
      proc_ctrl <= `CMC_PROC_CTRL_RST | {3'h0, cdef_s[1], 4'h0};
    end else if (wr_pulse) begin
      if (wr_addr == `CMC_PERIPH_CTRL_OFS) begin
        periph_ctrl <= wr_data;
      end
      if (wr_addr == `CMC_PROC_CTRL_OFS) begin
        proc_ctrl <= wr_data;
      end
    end
  end
  function automatic logic [7:0] read_reg(input logic [7:0] a, input logic [7:0] p1,
                                          input logic [7:0] p2);
    read_reg = 8'h00;
    if (a == `CMC_PERIPH_CTRL_OFS) begin
      read_reg = p1;
    end else if (a == `CMC_PROC_CTRL_OFS) begin
      read_reg = p2;
    end
  endfunction : read_reg

  // ****************************************
  // mode decode
  // ****************************************
  logic sleep_req;
  logic next_wait;
  logic next_lp;
  logic proc_off;
  assign sleep_req = slp_s[1] & periph_ctrl[`CMC_SLEEP_PIN_EN_BIT];
  assign next_wait = sleep_req & ~periph_ctrl[`CMC_SLEEP_KIND_BIT];
  assign next_lp = sleep_req & periph_ctrl[`CMC_SLEEP_KIND_BIT];
  assign proc_off = next_wait | (next_lp & proc_ctrl[`CMC_PROC_OFF_BIT]);
  logic [2:0] next_proc_v;
  always_comb begin
    if (next_lp) begin
      next_proc_v = {1'b0, proc_ctrl[`CMC_PROC_SLP_HI:`CMC_PROC_SLP_LO]};
    end else begin
      next_proc_v = proc_ctrl[`CMC_PROC_V_HI:`CMC_PROC_V_LO];
    end
  end

  // ****************************************
  // registered control outputs
  // ****************************************
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      pfm_allowed_out <= 1'b1;
      undervoltage_threshold_sel_out <= 2'h0;
      peripheral_voltage_sel_out <= 2'h0;
      peripheral_enable_out <= 1'b1;
      peripheral_discharge_out <= 1'b0;
      processor_voltage_sel_out <= 3'h0;
      processor_enable_out <= 1'b1;
      processor_discharge_out <= 1'b0;
      motor_drive_out <= 1'b0;
      wait_mode_out <= 1'b0;
      low_power_out <= 1'b0;
    end else begin
      pfm_allowed_out <= ~periph_ctrl[`CMC_FORCED_PWM_BIT];
      undervoltage_threshold_sel_out <= periph_ctrl[`CMC_UVLO_HI:`CMC_UVLO_LO];
      peripheral_voltage_sel_out <= periph_ctrl[`CMC_PERIPH_V_HI:`CMC_PERIPH_V_LO];
      peripheral_enable_out <= ~next_wait;
      peripheral_discharge_out <= next_wait & periph_ctrl[`CMC_PERIPH_DIS_BIT];
      processor_voltage_sel_out <= next_proc_v;
      processor_enable_out <= ~proc_off;
      processor_discharge_out <= proc_off & proc_ctrl[`CMC_PROC_DIS_BIT];
      motor_drive_out <= proc_ctrl[`CMC_MOTOR_BIT];
      wait_mode_out <= next_wait;
      low_power_out <= next_lp;
    end
  end

  // ****************************************
  // serial slave
  // ****************************************
  cmc_pkg::cmc_ser_state_t st;
  logic [3:0] cnt;
  logic [7:0] shreg;
  logic [7:0] rbuf;
  logic [7:0] ptr;
  logic rw;
  logic [7:0] rd_cur;
  logic [7:0] rd_nxt;
  assign rd_cur = read_reg(ptr, periph_ctrl, proc_ctrl);
  assign rd_nxt = read_reg(ptr + 8'h01, periph_ctrl, proc_ctrl);
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      st <= cmc_pkg::ST_IDLE;
      cnt <= 4'h0;
      shreg <= 8'h00;
      rbuf <= 8'h00;
      ptr <= 8'h00;
      rw <= 1'b0;
      sda_oe_out <= 1'b0;
      sda_out <= 1'b0;
      wr_pulse <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      wr_pulse <= 1'b0;
      if (stop_cond) begin
        st <= cmc_pkg::ST_IDLE;
        sda_oe_out <= 1'b0;
      end else if (start_cond) begin
        st <= cmc_pkg::ST_ADDR;
        cnt <= 4'h0;
        sda_oe_out <= 1'b0;
      end else if (scl_rise) begin
        shreg <= {shreg[6:0], sda_s[1]};
        cnt <= cnt + 4'h1;
      end else if (scl_fall) begin
        case (st)
          cmc_pkg::ST_ADDR: begin
            if (cnt == `CMC_BIT_COUNT) begin
              if (shreg[7:1] == `CMC_DEV_ADDR) begin
                sda_oe_out <= 1'b1;
                rw <= shreg[0];
                st <= cmc_pkg::ST_AACK;
              end else begin
                st <= cmc_pkg::ST_IDLE;
              end
            end
          end
          cmc_pkg::ST_AACK: begin
            cnt <= 4'h0;
            if (rw) begin
              rbuf <= rd_cur << 1;
              sda_oe_out <= ~rd_cur[7];
              st <= cmc_pkg::ST_RD;
            end else begin
              sda_oe_out <= 1'b0;
              st <= cmc_pkg::ST_PTR;
            end
          end
          cmc_pkg::ST_PTR: begin
            if (cnt == `CMC_BIT_COUNT) begin
              ptr <= shreg;
              sda_oe_out <= 1'b1;
              st <= cmc_pkg::ST_PACK;
            end
          end
          cmc_pkg::ST_PACK, cmc_pkg::ST_WACK: begin
            if (st == cmc_pkg::ST_WACK) begin
              ptr <= ptr + 8'h01;
            end
            sda_oe_out <= 1'b0;
            cnt <= 4'h0;
            st <= cmc_pkg::ST_WR;
          end
          cmc_pkg::ST_WR: begin
            if (cnt == `CMC_BIT_COUNT) begin
              wr_pulse <= 1'b1;
              wr_addr <= ptr;
              wr_data <= shreg;
              sda_oe_out <= 1'b1;
              st <= cmc_pkg::ST_WACK;
            end
          end
          cmc_pkg::ST_RD: begin
            if (cnt == `CMC_BIT_COUNT) begin
              sda_oe_out <= 1'b0;
              st <= cmc_pkg::ST_RACK;
            end else begin
              sda_oe_out <= ~rbuf[7];
              rbuf <= {rbuf[6:0], 1'b0};
            end
          end
          cmc_pkg::ST_RACK: begin
            cnt <= 4'h0;
            if (!shreg[0]) begin
              rbuf <= rd_nxt << 1;
              sda_oe_out <= ~rd_nxt[7];
              ptr <= ptr + 8'h01;
              st <= cmc_pkg::ST_RD;
            end else begin
              st <= cmc_pkg::ST_IDLE;
            end
          end
          default: begin
            sda_oe_out <= 1'b0;
          end
        endcase
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  logic rst_q;
  always_ff @(posedge mclk_in) begin
    rst_q <= rst_in;
  end
  sequence s_sleep_lp;
    sleep_req && periph_ctrl[`CMC_SLEEP_KIND_BIT];
  endsequence
  sequence s_lp_out;
    low_power_out && !wait_mode_out;
  endsequence
  chk_pfm_free: assert property (!periph_ctrl[7] |=> pfm_allowed_out)
    else $error("pfm blocked without forced pwm");
  chk_pfm_forced: assert property (periph_ctrl[7] |=> !pfm_allowed_out)
    else $error("pfm allowed under forced pwm");
  chk_uvlo_field: assert property (!rst_q |=>
    undervoltage_threshold_sel_out == $past(periph_ctrl[6:5]))
    else $error("threshold select mismatch");
  chk_wait_entry: assert property (slp_s[1] && periph_ctrl[3] && !periph_ctrl[4] |=> wait_mode_out)
    else $error("wait mode not entered");
  chk_lp_entry: assert property (s_sleep_lp |=> s_lp_out)
    else $error("low-power mode not entered");
  chk_pin_gated: assert property (!periph_ctrl[3] |=> !wait_mode_out && !low_power_out)
    else $error("sleep pin acted while gated");
  chk_main_dis: assert property (##1 peripheral_discharge_out == $past(next_wait && periph_ctrl[2]))
    else $error("peripheral discharge wrong");
  chk_periph_sel: assert property (!rst_q |=>
    peripheral_voltage_sel_out == $past(periph_ctrl[1:0]))
    else $error("peripheral voltage select mismatch");
  chk_strap_main: assert property (rst_q |-> periph_ctrl == {7'h19, $past(pdef_s[1])})
    else $error("peripheral strap not taken");
  chk_strap_core: assert property (rst_q |-> proc_ctrl[6:4] == {2'h3, $past(cdef_s[1])})
    else $error("processor strap not taken");
  chk_core_off: assert property (s_sleep_lp |=> processor_enable_out == !$past(proc_ctrl[7]))
    else $error("processor off in sleep wrong");
  chk_sleep_code: assert property (s_sleep_lp |=> processor_voltage_sel_out == {1'b0, $past(proc_ctrl[3:2])})
    else $error("sleep voltage code wrong");
  chk_core_return: assert property (!rst_q && !next_lp |=>
    processor_voltage_sel_out == $past(proc_ctrl[6:4]))
    else $error("processor code not restored");
  chk_motor_drive: assert property (##1 motor_drive_out == $past(proc_ctrl[1]))
    else $error("motor drive mismatch");
  chk_core_dis: assert property (proc_ctrl[0] && (next_wait || (next_lp && proc_ctrl[7])) |=> processor_discharge_out)
    else $error("processor discharge missing");
  chk_write_back: assert property (wr_pulse && wr_addr == 8'h0C |=> periph_ctrl == $past(wr_data))
    else $error("register write lost");
  chk_write_proc: assert property (wr_pulse && wr_addr == 8'h0D |=>
    proc_ctrl == $past(wr_data))
    else $error("processor register write lost");
endmodule : cmc_top
`default_nettype wire
